// file: inc/sssmc_pkg.sv
// constants, types and decode helper for the supply supervisor mode control
// assumes a single 25 MHz clock and a 32-bit AXI4-Lite register port
package sssmc_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int FULL_SETTLE_NS = 2000;
    localparam int NORM_SETTLE_NS = 150000;
    localparam int SLOW_WAKE_NS = 150000;
    localparam int FAST_WAKE_NS = 5000;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] FULL_SETTLE_CYC = CNT_W'((FULL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] NORM_SETTLE_CYC = CNT_W'((NORM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SLOW_WAKE_CYC = CNT_W'((SLOW_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FAST_WAKE_CYC = CNT_W'((FAST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

    // ==========================================================
    // register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CORE_CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] SUPPLY_CTRL_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] FLAGS_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] STATE_ADDR = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_W = 9;
    localparam int EVT_W = 4;

    typedef struct packed {
        logic overvoltageProtectEnable;
        logic sideAutoControl;
        logic monitorFullPerf;
        logic monitorEnable;
        logic supervisorFullPerf;
        logic supervisorSleepMode;
        logic supervisorEnable;
        logic [1:0] coreLevel;
    } sssmc_ctrl_type;

    localparam sssmc_ctrl_type CTRL_RESET = 9'h02C;
    localparam sssmc_ctrl_type CORE_CTRL_MASK = 9'h0FF;

    // sticky event bits, same layout in the mask register
    typedef struct packed {
        logic overvoltageEvent;
        logic coreUndervoltageEvent;
        logic supplySettleDone;
        logic coreSettleDone;
    } sssmc_evt_type;

    localparam sssmc_evt_type EVT_RESET = 4'h0;

    typedef enum logic [1:0] {
        COMP_OFF = 2'h0,
        COMP_NORMAL = 2'h1,
        COMP_FULL = 2'h2
    } sssmc_comp_type;

    typedef enum logic [2:0] {
        WAKE_RUN = 3'h1,
        WAKE_DEEP = 3'h2,
        WAKE_RISE = 3'h4
    } sssmc_wake_type;

    // keep: sleep-mode bit for a supervisor, always 1 for a monitor
    function automatic sssmc_comp_type sssmc_decode(input logic en, input logic keep, input logic fp,
                                                    input logic deep, input logic auto);
        sssmc_comp_type s;
        if (!en) begin
            s = COMP_OFF;
        end else if (!deep) begin
            s = fp ? COMP_FULL : COMP_NORMAL;
        end else if (!keep) begin
            s = COMP_OFF;
        end else if (auto) begin
            s = fp ? COMP_NORMAL : COMP_OFF;
        end else begin
            s = fp ? COMP_FULL : COMP_NORMAL;
        end
        return s;
    endfunction
endpackage

// file: rtl/sssmc_top.sv
// supply supervisor mode control: comparator states, settle delays,
// wake timing and supervisor resets, with an AXI4-Lite register port
// assumes all inputs synchronous to clk; one write and one read in flight
`timescale 1ns/1ps

// How it works
// - in full performance the core supervisor settles for about 2 us after a change.
// - in normal performance the core supervisor settles for about 150 us after a change.
// - a raised core level not reached when the settle delay ends gives an undervoltage reset.
// - core supervisor and monitor decode off, normal or full from enable, mode, performance and power mode.
// - the supply side decodes the same way, and automatic control downgrades each comparator in deep sleep.
// - wake-up is slow whenever an enabled core supervisor or monitor runs in normal performance.
// - with overvoltage protection enabled the supply monitor raises a power-on reset on overvoltage.
// - a power-up clear returns the wake logic to normal running.
module sssmc_top import sssmc_pkg::*; #(
    parameter logic [CNT_W-1:0] FAST_WAKE_CYCLES = FAST_WAKE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic deepSleepRequest,
    input wire logic wakeInterrupt,
    input wire logic powerUpClear,
    input wire logic coreVoltageOk,
    input wire logic supplyAboveLimit,
    output sssmc_comp_type coreSupervisorState,
    output sssmc_comp_type coreMonitorState,
    output sssmc_comp_type supplySupervisorState,
    output sssmc_comp_type supplyMonitorState,
    output logic wakeSlow,
    output logic cpuRun,
    output logic deviceReset,
    output logic irq
);
    // ==========================================================
    // state
    sssmc_ctrl_type coreCtrl_reg, coreCtrl_next, supplyCtrl_reg, supplyCtrl_next;
    logic [CNT_W-1:0] coreCnt_reg, coreCnt_next, supplyCnt_reg, supplyCnt_next;
    logic coreRaise_reg, coreRaise_next;
    sssmc_evt_type events_reg, events_next, mask_reg, mask_next;
    sssmc_wake_type wake_reg, wake_next;
    logic [CNT_W-1:0] wakeCnt_reg, wakeCnt_next;
    sssmc_comp_type coreSup_reg, coreSup_next, coreMon_reg, coreMon_next;
    sssmc_comp_type supSup_reg, supSup_next, supMon_reg, supMon_next;
    logic wakeSlow_reg, wakeSlow_next, reset_reg, reset_next, irq_reg, irq_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic writeFire, readFire, coreWr, supplyWr, flagsWr, maskWr;
    logic coreFlag, supplyFlag, coreExpire, supplyExpire, deep, underVolt, overVolt;
    logic [CTRL_W-1:0] laneMask;
    sssmc_ctrl_type coreNew, supplyNew;
    sssmc_evt_type evtSet, evtClr;

    // ==========================================================
    // bus handshake
    // address and data are taken together; a master offering only one waits
    assign writeFire = awvalid && wvalid && !bvalid_reg;
    assign readFire = arvalid && !rvalid_reg;
    assign awready = writeFire;
    assign wready = writeFire;
    assign arready = !rvalid_reg;
    assign laneMask = {wstrb[1], {8{wstrb[0]}}};
    assign coreWr = writeFire && awaddr == CORE_CTRL_ADDR;
    assign supplyWr = writeFire && awaddr == SUPPLY_CTRL_ADDR;
    assign flagsWr = writeFire && awaddr == FLAGS_ADDR;
    assign maskWr = writeFire && awaddr == MASK_ADDR;
    // core register has no overvoltage bit
    assign coreNew = ((coreCtrl_reg & ~laneMask) | (wdata[CTRL_W-1:0] & laneMask)) & CORE_CTRL_MASK;
    assign supplyNew = (supplyCtrl_reg & ~laneMask) | (wdata[CTRL_W-1:0] & laneMask);
    assign coreFlag = coreCnt_reg != CNT_ZERO;
    assign supplyFlag = supplyCnt_reg != CNT_ZERO;
    assign coreExpire = coreCnt_reg == CNT_ONE && !coreWr;
    assign supplyExpire = supplyCnt_reg == CNT_ONE && !supplyWr;
    assign deep = wake_reg == WAKE_DEEP;
    // a raise still short of its level when the window closes is a real undervoltage
    assign underVolt = coreExpire && coreRaise_reg && !coreVoltageOk && coreSup_reg != COMP_OFF;
    assign overVolt = supplyCtrl_reg.overvoltageProtectEnable && supMon_reg != COMP_OFF && supplyAboveLimit;

    // ==========================================================
    // control, settle timers and events
    always_comb begin
        coreCtrl_next = coreWr ? coreNew : coreCtrl_reg;
        supplyCtrl_next = supplyWr ? supplyNew : supplyCtrl_reg;
        coreCnt_next = coreCnt_reg;
        if (coreWr) begin
            coreCnt_next = coreNew.supervisorFullPerf ? FULL_SETTLE_CYC : NORM_SETTLE_CYC;
        end else if (coreFlag) begin
            coreCnt_next = coreCnt_reg - CNT_ONE;
        end
        supplyCnt_next = supplyCnt_reg;
        if (supplyWr) begin
            supplyCnt_next = supplyNew.supervisorFullPerf ? FULL_SETTLE_CYC : NORM_SETTLE_CYC;
        end else if (supplyFlag) begin
            supplyCnt_next = supplyCnt_reg - CNT_ONE;
        end
        coreRaise_next = coreRaise_reg;
        if (coreWr) begin
            coreRaise_next = coreRaise_reg || (coreNew.coreLevel > coreCtrl_reg.coreLevel);
        end else if (coreExpire) begin
            coreRaise_next = 1'b0;
        end
        evtSet = '{overVolt, underVolt, supplyExpire, coreExpire};
        evtClr = flagsWr && wstrb[0] ? sssmc_evt_type'(wdata[EVT_W-1:0]) : EVT_RESET;
        // a new event beats a clear in the same cycle
        events_next = (events_reg & ~evtClr) | evtSet;
        mask_next = maskWr && wstrb[0] ? sssmc_evt_type'(wdata[EVT_W-1:0]) : mask_reg;
        irq_next = |(events_next & mask_next);
        reset_next = underVolt || overVolt;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreCtrl_reg <= CTRL_RESET;
            supplyCtrl_reg <= CTRL_RESET;
            coreCnt_reg <= CNT_ZERO;
            supplyCnt_reg <= CNT_ZERO;
            coreRaise_reg <= 1'b0;
            events_reg <= EVT_RESET;
            mask_reg <= EVT_RESET;
            irq_reg <= 1'b0;
            reset_reg <= 1'b0;
        end else begin
            coreCtrl_reg <= coreCtrl_next;
            supplyCtrl_reg <= supplyCtrl_next;
            coreCnt_reg <= coreCnt_next;
            supplyCnt_reg <= supplyCnt_next;
            coreRaise_reg <= coreRaise_next;
            events_reg <= events_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            reset_reg <= reset_next;
        end
    end

    // ==========================================================
    // comparator states and wake sequence
    always_comb begin
        coreSup_next = sssmc_decode(coreCtrl_reg.supervisorEnable, coreCtrl_reg.supervisorSleepMode,
            coreCtrl_reg.supervisorFullPerf, deep, coreCtrl_reg.sideAutoControl);
        coreMon_next = sssmc_decode(coreCtrl_reg.monitorEnable, 1'b1,
            coreCtrl_reg.monitorFullPerf, deep, coreCtrl_reg.sideAutoControl);
        supSup_next = sssmc_decode(supplyCtrl_reg.supervisorEnable, supplyCtrl_reg.supervisorSleepMode,
            supplyCtrl_reg.supervisorFullPerf, deep, supplyCtrl_reg.sideAutoControl);
        supMon_next = sssmc_decode(supplyCtrl_reg.monitorEnable, 1'b1,
            supplyCtrl_reg.monitorFullPerf, deep, supplyCtrl_reg.sideAutoControl);
        wakeSlow_next = (coreCtrl_reg.supervisorEnable && !coreCtrl_reg.supervisorFullPerf)
            || (coreCtrl_reg.monitorEnable && !coreCtrl_reg.monitorFullPerf);
        wake_next = wake_reg;
        wakeCnt_next = wakeCnt_reg;
        if (powerUpClear) begin
            wake_next = WAKE_RUN;
            wakeCnt_next = CNT_ZERO;
        end else begin
            unique case (wake_reg)
                WAKE_RUN: begin
                    // entry is held off while a settle delay runs
                    if (deepSleepRequest && !coreFlag && !supplyFlag) begin
                        wake_next = wakeInterrupt ? WAKE_RISE : WAKE_DEEP;
                        wakeCnt_next = wakeSlow_reg ? SLOW_WAKE_CYC : FAST_WAKE_CYCLES;
                    end
                end
                WAKE_DEEP: begin
                    if (wakeInterrupt) begin
                        wake_next = WAKE_RISE;
                        wakeCnt_next = wakeSlow_reg ? SLOW_WAKE_CYC : FAST_WAKE_CYCLES;
                    end
                end
                WAKE_RISE: begin
                    if (wakeCnt_reg <= CNT_ONE) begin
                        wake_next = WAKE_RUN;
                        wakeCnt_next = CNT_ZERO;
                    end else begin
                        wakeCnt_next = wakeCnt_reg - CNT_ONE;
                    end
                end
                default: begin
                    wake_next = WAKE_RUN;
                    wakeCnt_next = CNT_ZERO;
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreSup_reg <= COMP_OFF;
            coreMon_reg <= COMP_OFF;
            supSup_reg <= COMP_OFF;
            supMon_reg <= COMP_OFF;
            wakeSlow_reg <= 1'b0;
            wake_reg <= WAKE_RUN;
            wakeCnt_reg <= CNT_ZERO;
        end else begin
            coreSup_reg <= coreSup_next;
            coreMon_reg <= coreMon_next;
            supSup_reg <= supSup_next;
            supMon_reg <= supMon_next;
            wakeSlow_reg <= wakeSlow_next;
            wake_reg <= wake_next;
            wakeCnt_reg <= wakeCnt_next;
        end
    end

    // ==========================================================
    // bus answers
    always_comb begin
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (writeFire) begin
            bvalid_next = 1'b1;
            bresp_next = (coreWr || supplyWr || flagsWr || maskWr || awaddr == STATE_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_next = 1'b0;
        end
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (readFire) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            unique case (araddr)
                CORE_CTRL_ADDR: rdata_next = {23'h000000, coreCtrl_reg};
                SUPPLY_CTRL_ADDR: rdata_next = {23'h000000, supplyCtrl_reg};
                FLAGS_ADDR: rdata_next = {26'h0000000, supplyFlag, coreFlag, events_reg};
                MASK_ADDR: rdata_next = {28'h0000000, mask_reg};
                STATE_ADDR: rdata_next = {22'h000000, wake_reg == WAKE_RUN, wakeSlow_reg,
                    supMon_reg, supSup_reg, coreMon_reg, coreSup_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_next = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else begin
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign coreSupervisorState = coreSup_reg;
    assign coreMonitorState = coreMon_reg;
    assign supplySupervisorState = supSup_reg;
    assign supplyMonitorState = supMon_reg;
    assign wakeSlow = wakeSlow_reg;
    assign cpuRun = wake_reg == WAKE_RUN;
    assign deviceReset = reset_reg;
    assign irq = irq_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // long windows are too deep to unroll: check the load and every countdown step instead
    sequence s_settleEnds;
        coreFlag [*8] ##[1:50] (!coreFlag || coreWr);
    endsequence
    property p_fullSettle;
        coreWr && coreNew.supervisorFullPerf |=> s_settleEnds;
    endproperty
    a_fullSettle: assert property (p_fullSettle) else $error("full settle not near 2 us");
    property p_normSettle;
        (coreWr && !coreNew.supervisorFullPerf |=> coreCnt_reg == NORM_SETTLE_CYC)
            and (coreFlag && !coreWr |=> coreCnt_reg == $past(coreCnt_reg) - CNT_ONE);
    endproperty
    a_normSettle: assert property (p_normSettle) else $error("normal settle ended early");
    property p_underVolt;
        coreExpire && coreRaise_reg && !coreVoltageOk && coreSup_reg != COMP_OFF
            |=> deviceReset && events_reg.coreUndervoltageEvent;
    endproperty
    a_underVolt: assert property (p_underVolt) else $error("missed undervoltage reset");
    property p_coreOff;
        !coreCtrl_reg.supervisorEnable && !coreCtrl_reg.monitorEnable && !coreWr
            |=> coreSupervisorState == COMP_OFF && coreMonitorState == COMP_OFF;
    endproperty
    a_coreOff: assert property (p_coreOff) else $error("disabled core comparator not off");
    property p_autoDrop;
        deep && supplyCtrl_reg.sideAutoControl && supplyCtrl_reg.monitorEnable
            && supplyCtrl_reg.monitorFullPerf && !supplyWr |=> supplyMonitorState == COMP_NORMAL;
    endproperty
    a_autoDrop: assert property (p_autoDrop) else $error("auto control did not drop monitor");
    property p_slowWake;
        (wake_reg == WAKE_DEEP && wakeInterrupt && wakeSlow_reg && !powerUpClear |=> wakeCnt_reg == SLOW_WAKE_CYC)
            and (wake_reg == WAKE_RISE && wakeCnt_reg > CNT_ONE && !powerUpClear
            |=> wake_reg == WAKE_RISE && wakeCnt_reg == $past(wakeCnt_reg) - CNT_ONE);
    endproperty
    a_slowWake: assert property (p_slowWake) else $error("slow wake too short");
    property p_ovp;
        overVolt |=> deviceReset ##0 $past(supplyCtrl_reg.overvoltageProtectEnable);
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage reset missing");
    property p_puc;
        powerUpClear |=> cpuRun;
    endproperty
    a_puc: assert property (p_puc) else $error("power-up clear did not restore run");
    property p_flagSet;
        (coreWr |=> coreFlag) and (supplyWr |=> supplyFlag);
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("settle flag not set by write");
    property p_wake;
        wake_reg == WAKE_DEEP && wakeInterrupt && !powerUpClear |=> wake_reg == WAKE_RISE;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt lost in deep sleep");
endmodule

// file: sim/sssmc_pmc_model.sv
// power-mode controller model: turns bench commands into sleep and wake requests
// assumes the block's clk and reset_n; wakeDelay sets how slowly it answers
`timescale 1ns/1ps
module sssmc_pmc_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sleepCmd,
    input wire logic wakeCmd,
    input wire logic [7:0] wakeDelay,
    output logic deepSleepRequest,
    output logic wakeInterrupt
);
    logic [7:0] waitCount_reg;
    // ==========================================================
    // request and interrupt timing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            deepSleepRequest <= 1'b0;
            wakeInterrupt <= 1'b0;
            waitCount_reg <= 8'h00;
        end else begin
            // level request, held while software stays asleep
            deepSleepRequest <= sleepCmd;
            if (!wakeCmd) begin
                waitCount_reg <= 8'h00;
                wakeInterrupt <= 1'b0;
            end else if (waitCount_reg >= wakeDelay) begin
                wakeInterrupt <= 1'b1;
            end else begin
                waitCount_reg <= waitCount_reg + 8'h01;
            end
        end
    end
endmodule

// file: sim/tb_top.sv
// testbench for the supply supervisor mode control: register tasks, sleep and wake runs
// assumes the power-mode controller model and a 25 MHz clock
`timescale 1ns/1ps
module tb_top import sssmc_pkg::*;;
    logic clk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, coreVoltageOk = 1'b1, supplyAboveLimit = 1'b0, powerUpClear = 1'b0;
    logic sleepCmd = 1'b0, wakeCmd = 1'b0, deepSleepRequest, wakeInterrupt, awready, wready, bvalid;
    logic arready, rvalid, wakeSlow, cpuRun, deviceReset, irq, slow;
    logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r, wr;
    logic [7:0] wakeDelay = 8'h00;
    logic [8:0] v;
    logic [8:0] cfg [6] = '{9'h00C, 9'h034, 9'h0FC, 9'h0AC, 9'h000, 9'h05C};
    sssmc_comp_type coreSupervisorState, coreMonitorState, supplySupervisorState, supplyMonitorState;
    int errorCnt = 0, nChecks = 0, cyc = 0, t0;

    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // small wake count keeps the fast case short
    sssmc_top #(.FAST_WAKE_CYCLES(12'h004)) sssmc_top_i (.clk, .reset_n, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .deepSleepRequest, .wakeInterrupt, .powerUpClear, .coreVoltageOk,
        .supplyAboveLimit, .coreSupervisorState, .coreMonitorState, .supplySupervisorState,
        .supplyMonitorState, .wakeSlow, .cpuRun, .deviceReset, .irq);
    sssmc_pmc_model sssmc_pmc_model_i (.clk, .reset_n, .sleepCmd, .wakeCmd, .wakeDelay,
        .deepSleepRequest, .wakeInterrupt);

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // readies are looked at mid-cycle, the transfer happens at the next rising edge
    task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
        @(posedge clk);
        awaddr <= a;
        wdata <= dat;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            wr = bresp;
        end while (bvalid !== 1'b1);
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            dat = rdata;
            rsp = rresp;
        end while (rvalid !== 1'b1);
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic wait_run(input logic b);
        do @(negedge clk); while (cpuRun !== b);
        @(posedge clk);
    endtask

    task automatic pause(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [1:0] exp_state(input logic en, keep, fp, deep, auto);
        if (!en || (deep && !keep) || (deep && auto && !fp)) return 2'h0;
        return (fp && !(deep && auto)) ? 2'h2 : 2'h1;
    endfunction

    function automatic logic [31:0] exp_all(input logic [8:0] c, input logic dp);
        logic [1:0] s;
        logic [1:0] m;
        s = exp_state(c[2], c[3], c[4], dp, c[7]);
        m = exp_state(c[5], 1'b1, c[6], dp, c[7]);
        return {24'h0, s, m, s, m};
    endfunction

    // ==========================================================
    // tests
    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        axr(CORE_CTRL_ADDR, d, r);
        chk(d, 32'h0000002C);
        axr(STATE_ADDR, d, r);
        chk(d, 32'h00000355);
        axr(8'h14, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        axw(8'h14, 32'h00000000);
        chk(wr, RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            v = cfg[i];
            slow = (v[2] && !v[4]) || (v[5] && !v[6]);
            wakeDelay <= i[0] ? 8'h14 : 8'h00;
            axw(CORE_CTRL_ADDR, {23'h0, v});
            axw(SUPPLY_CTRL_ADDR, {23'h0, v});
            t0 = cyc;
            sleepCmd <= 1'b1;
            pause(3);
            chk(cpuRun, 1'b1);
            @(posedge clk);
            sleepCmd <= 1'b0;
            do axr(FLAGS_ADDR, d, r); while (d[5:4] !== 2'h0);
            chk((cyc - t0) > (v[4] ? 40 : 3740) && (cyc - t0) < (v[4] ? 60 : 3760), 1'b1);
            @(negedge clk);
            chk({coreSupervisorState, coreMonitorState, supplySupervisorState, supplyMonitorState}, exp_all(v, 1'b0));
            chk(wakeSlow, slow);
            @(posedge clk);
            sleepCmd <= 1'b1;
            wait_run(1'b0);
            sleepCmd <= 1'b0;
            pause(3);
            chk({coreSupervisorState, coreMonitorState, supplySupervisorState, supplyMonitorState}, exp_all(v, 1'b1));
            @(posedge clk);
            wakeCmd <= 1'b1;
            t0 = cyc;
            wait_run(1'b1);
            wakeCmd <= 1'b0;
            chk((cyc - t0) > 1000, slow);
        end
        // interrupt together with entry must still wake
        @(posedge clk);
        wakeDelay <= 8'h00;
        sleepCmd <= 1'b1;
        wakeCmd <= 1'b1;
        wait_run(1'b0);
        sleepCmd <= 1'b0;
        t0 = cyc;
        wait_run(1'b1);
        wakeCmd <= 1'b0;
        chk((cyc - t0) < 20, 1'b1);
        sleepCmd <= 1'b1;
        wait_run(1'b0);
        sleepCmd <= 1'b0;
        pause(5);
        chk(cpuRun, 1'b0);
        @(posedge clk);
        powerUpClear <= 1'b1;
        @(posedge clk);
        powerUpClear <= 1'b0;
        @(negedge clk);
        chk(cpuRun, 1'b1);
        @(posedge clk);
        coreVoltageOk <= 1'b0;
        axw(CORE_CTRL_ADDR, 32'h00000015);
        t0 = cyc;
        do @(negedge clk); while (deviceReset !== 1'b1);
        chk((cyc - t0) > 40 && (cyc - t0) < 60, 1'b1);
        @(posedge clk);
        coreVoltageOk <= 1'b1;
        axr(FLAGS_ADDR, d, r);
        chk(d[2], 1'b1);
        pause(1);
        chk(irq, 1'b0);
        axw(MASK_ADDR, 32'h00000004);
        chk(wr, RESP_OKAY);
        pause(2);
        chk(irq, 1'b1);
        axw(FLAGS_ADDR, 32'h00000004);
        pause(2);
        chk(irq, 1'b0);
        axw(SUPPLY_CTRL_ADDR, 32'h00000120);
        pause(3);
        @(posedge clk);
        supplyAboveLimit <= 1'b1;
        pause(2);
        chk(deviceReset, 1'b1);
        @(posedge clk);
        supplyAboveLimit <= 1'b0;
        axr(FLAGS_ADDR, d, r);
        chk(d[3], 1'b1);
        end_of_test();
    end
endmodule
